/* File: rtl/tio_defs.svh */
`ifndef TIO_DEFS_SVH
`define TIO_DEFS_SVH
// Behaviour
// R1: Ports of 1, 4, 8, 16, 32 bits
// R2: All pins of a port share direction
// R3: Drive pins, or sample on a condition
// R4: Each software access completes in one cycle
// R5: Open-drain: zero pulls low, one floats
// R6: Serializer plus transfer register between pins, software
// R7: 16-bit counter per port times transfers
// R8: Counter readable; future transfer time programmable
// R9: Counter captured as timestamp each transfer
// R10: Enabled link disables the shared port pins
// R11: Narrower port wins shared pins over wider
// R12: Port always transfers at its nominal width
// R13: Six clock blocks; block 0 is reference
// R14: Clock block sourced and divided from pin
// R15: Inbound strobe qualifies input; outbound strobe accompanies
// R16: Reset attaches every port to block 0
// R17: Transfer signals an event straight to tile
// R18: Counter steps per clock tick, wraps

// Sizes
`define TIO_NPORTS 5
`define TIO_NCB 6
`define TIO_NPINS 32
`define TIO_ADDR_W 6
`define TIO_CNT_W 16

// Per-port register word indices; port k sits at addr[5:3] == k
`define TIO_REG_CTRL 3'h0
`define TIO_REG_COND 3'h1
`define TIO_REG_TIME 3'h2
`define TIO_REG_DATA 3'h3
`define TIO_REG_COUNT 3'h4
`define TIO_REG_STAMP 3'h5

// Global register word indices
`define TIO_REG_LINK 6'h28
`define TIO_REG_IRQ_STAT 6'h29
`define TIO_REG_IRQ_MASK 6'h2a
`define TIO_CB_PAGE 3'h6

// Control word fields
`define TIO_CTRL_EN 0
`define TIO_CTRL_DIR_OUT 1
`define TIO_CTRL_OD 2
`define TIO_CTRL_CLK_LSB 3
`define TIO_CTRL_COND_LSB 6
`define TIO_CTRL_SIN 8
`define TIO_CTRL_SOUT 9
`define TIO_CTRL_VALID 16
`define TIO_CTRL_BUSY 17
`define TIO_CTRL_MASK 32'h0000_03ff

// Clock block fields
`define TIO_CB_SRC 0
`define TIO_CB_DIV_LSB 8

// Reset values
`define TIO_CTRL_RESET 32'h0000_0000
`define TIO_CB_RESET 16'h0000

// Pins taken by the inter-chip link when enabled
`define TIO_LINK_LO 16
`define TIO_LINK_HI 19

`endif

/* File: rtl/tio_pkg.sv */
package tio_pkg;

  // Sampling condition applied before each input step
  typedef enum logic [1:0] {
    COND_NONE = 2'h0,
    COND_EQ = 2'h1,
    COND_NE = 2'h2
  } tio_cond_type;

  // Port sequencer, Gray along idle, busy, hold
  typedef enum logic [1:0] {
    PS_IDLE = 2'h0,
    PS_BUSY = 2'h1,
    PS_HOLD = 2'h3
  } tio_state_type;

  // Nominal width of each port index
  function automatic int tio_port_width(input int k);
    case (k)
      0: return 1;
      1: return 4;
      2: return 8;
      3: return 16;
      default: return 32;
    endcase
  endfunction : tio_port_width

endpackage : tio_pkg

/* File: rtl/tio_clock_block.sv */
`timescale 1ns/1ns
module tio_clock_block (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Source pin, already synchronised
  input wire logic pin_level,
  // Configuration
  input wire logic src_pin,
  input wire logic [7:0] div,
  // Output tick, one cycle per block edge
  output logic tick
);

  logic pin_prev;
  logic [7:0] div_cnt;
  logic src_edge;

  // Previous pin level for rising edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_prev <= 1'b0;
    else
      pin_prev <= pin_level;
  end

  // Source edge: reference every cycle, or rising pin edge
  assign src_edge = src_pin ? (pin_level & ~pin_prev) : 1'b1;  // R14

  // Divide source edges by div + 1
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_cnt <= 8'h00;
      tick <= 1'b0;
    end
    else if (src_edge)
    begin
      tick <= (div_cnt == div);  // R14
      div_cnt <= (div_cnt == div) ? 8'h00 : div_cnt + 8'h01;
    end
    else
      tick <= 1'b0;
  end

endmodule : tio_clock_block

/* File: rtl/tio_port_block.sv */
`timescale 1ns/1ns
`include "tio_defs.svh"
module tio_port_block (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Pins
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe_n,
  // Strobes, one per port
  input wire logic [4:0] inbound_strobe,
  output logic [4:0] outbound_strobe,
  // Events to the tile and interrupt
  output logic [4:0] port_event,
  output logic irq
);

  localparam int NP = `TIO_NPORTS;

  // Pin and strobe synchronisers
  logic [31:0] pin_meta;
  logic [31:0] pin_sync;
  logic [4:0] stb_meta;
  logic [4:0] stb_sync;

  // Global state
  logic link_en;
  logic [4:0] irq_stat;
  logic [4:0] irq_mask;
  logic [15:0] cb_cfg [1:5];
  logic [5:0] cb_tick;

  // Per-port values exported from the generate loop
  logic [31:0] ctrl [NP];
  logic [31:0] port_rd [NP];
  logic [31:0] lane_out [NP];
  logic [4:0] done;
  logic [NP-1:0] own [32];

  // Two flip-flops before any pin or strobe is read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_meta <= 32'h0000_0000;
      pin_sync <= 32'h0000_0000;
      stb_meta <= 5'h00;
      stb_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      stb_meta <= inbound_strobe;
      stb_sync <= stb_meta;
    end
  end

  // Link enable and clock block configuration
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      link_en <= 1'b0;
      for (int j = 1; j < `TIO_NCB; j++)
        cb_cfg[j] <= `TIO_CB_RESET;
    end
    else if (wr)
    begin
      if (addr == `TIO_REG_LINK)
        link_en <= wdata[0];
      for (int j = 1; j < `TIO_NCB; j++)
        if (addr == {`TIO_CB_PAGE, 3'(j)})
          cb_cfg[j] <= wdata[15:0];
    end
  end

  // Block 0 is the reference clock, which equals clk
  assign cb_tick[0] = 1'b1;  // R13

  // Programmable clock blocks fed from the 1-bit port pin
  for (genvar j = 1; j < `TIO_NCB; j++)
  begin : cb_g
    tio_clock_block u_cb (
      .clk(clk),
      .rst(rst),
      .pin_level(pin_sync[0]),
      .src_pin(cb_cfg[j][`TIO_CB_SRC]),
      .div(cb_cfg[j][`TIO_CB_DIV_LSB +: 8]),
      .tick(cb_tick[j])
    );  // R13 R14
  end

  // Pin ownership: link first, then the narrowest enabled port
  for (genvar i = 0; i < 32; i++)
  begin : own_g
    always_comb
    begin
      own[i] = '0;
      if (!(link_en && i >= `TIO_LINK_LO && i <= `TIO_LINK_HI))  // R10
      begin
        for (int k = NP - 1; k >= 0; k--)
          if (ctrl[k][`TIO_CTRL_EN] && i < tio_pkg::tio_port_width(k))
          begin
            own[i] = '0;
            own[i][k] = 1'b1;  // R11
          end
      end
    end
  end

  // Per-port serializer, transfer register, counter and strobes
  for (genvar k = 0; k < NP; k++)
  begin : port_g
    localparam int W = tio_pkg::tio_port_width(k);  // R1
    localparam logic [4:0] LAST = 5'(32 / W - 1);
    logic [31:0] cond_val;
    logic [15:0] time_val;
    logic timed;
    logic [15:0] count;
    logic [15:0] stamp;
    logic [31:0] shreg;
    logic [31:0] xfer;
    logic [4:0] step_cnt;
    logic [31:0] lane_in;
    logic [31:0] lane_drv;
    logic [2:0] csel;
    logic tick;
    logic dir_out;
    logic gate;
    logic cond_ok;
    logic step;
    logic sel;
    logic step_q;
    logic tick_q;
    tio_pkg::tio_state_type state;
    tio_pkg::tio_cond_type cmode;

    assign sel = (addr[5:3] == 3'(k));
    assign dir_out = ctrl[k][`TIO_CTRL_DIR_OUT];  // R2
    assign csel = ctrl[k][`TIO_CTRL_CLK_LSB +: 3];
    assign tick = (csel < 3'(`TIO_NCB)) ? cb_tick[csel] : cb_tick[0];
    assign cmode = tio_pkg::tio_cond_type'(ctrl[k][`TIO_CTRL_COND_LSB +: 2]);

    // Lost pins read as zero, word width stays nominal
    always_comb
    begin
      lane_in = 32'h0000_0000;
      for (int i = 0; i < W; i++)
        lane_in[i] = pin_sync[i] & own[i][k];  // R12
    end

    // Conditional sampling on the pin value
    always_comb
    begin
      case (cmode)
        tio_pkg::COND_EQ: cond_ok = (lane_in[W-1:0] == cond_val[W-1:0]);  // R3
        tio_pkg::COND_NE: cond_ok = (lane_in[W-1:0] != cond_val[W-1:0]);  // R3
        default: cond_ok = 1'b1;
      endcase
    end

    // A step needs a tick, the scheduled time and the qualifiers
    assign gate = (!timed || count == time_val)  // R7 R8
      && (dir_out || cond_ok)
      && (dir_out || !ctrl[k][`TIO_CTRL_SIN] || stb_sync[k]);  // R15
    assign step = ctrl[k][`TIO_CTRL_EN] && state == tio_pkg::PS_BUSY && tick && gate;

    // Counter steps on each tick of the attached block
    always_ff @(posedge clk)
    begin
      if (rst)
        count <= 16'h0000;
      else if (tick)
        count <= count + 16'h0001;  // R18 R7
    end

    // Condition value and scheduled time
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        cond_val <= 32'h0000_0000;
        time_val <= 16'h0000;
        timed <= 1'b0;
      end
      else if (wr && sel && addr[2:0] == `TIO_REG_TIME)
      begin
        time_val <= wdata[15:0];
        timed <= 1'b1;  // R8
      end
      else
      begin
        if (wr && sel && addr[2:0] == `TIO_REG_COND)
          cond_val <= wdata;
        if (step)
          timed <= 1'b0;
      end
    end

    // Control word; reset leaves the port on clock block 0
    always_ff @(posedge clk)
    begin
      if (rst)
        ctrl[k] <= `TIO_CTRL_RESET;  // R16
      else if (wr && sel && addr[2:0] == `TIO_REG_CTRL)
        ctrl[k] <= wdata & `TIO_CTRL_MASK;
    end

    // Sequencer, serializer and transfer register
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        state <= tio_pkg::PS_IDLE;
        shreg <= 32'h0000_0000;
        xfer <= 32'h0000_0000;
        step_cnt <= 5'h00;
        stamp <= 16'h0000;
        lane_drv <= 32'h0000_0000;
      end
      else if (wr && sel && addr[2:0] == `TIO_REG_CTRL)
      begin
        state <= tio_pkg::PS_IDLE;
        step_cnt <= 5'h00;
      end
      else
      begin
        case (state)
          tio_pkg::PS_IDLE:
          begin
            if (dir_out && wr && sel && addr[2:0] == `TIO_REG_DATA)
            begin
              shreg <= wdata;  // R6
              step_cnt <= 5'h00;
              state <= tio_pkg::PS_BUSY;
            end
            else if (!dir_out && ctrl[k][`TIO_CTRL_EN])
            begin
              step_cnt <= 5'h00;
              state <= tio_pkg::PS_BUSY;
            end
          end
          tio_pkg::PS_BUSY:
          begin
            if (step)
            begin
              if (dir_out)
              begin
                lane_drv <= 32'(shreg[W-1:0]);  // R3 R12
                shreg <= 32'({32'h0000_0000, shreg} >> W);  // R6
              end
              else
                shreg <= 32'({lane_in, shreg} >> W);  // R6
              step_cnt <= step_cnt + 5'h01;
              if (step_cnt == LAST)
              begin
                stamp <= count;  // R9
                step_cnt <= 5'h00;
                if (dir_out)
                  state <= tio_pkg::PS_IDLE;
                else
                begin
                  xfer <= 32'({lane_in, shreg} >> W);  // R6
                  state <= tio_pkg::PS_HOLD;
                end
              end
            end
          end
          tio_pkg::PS_HOLD:
          begin
            if (rd && sel && addr[2:0] == `TIO_REG_DATA)
              state <= tio_pkg::PS_BUSY;
          end
          default: state <= tio_pkg::PS_IDLE;
        endcase
      end
    end

    // Outbound strobe trails the step by two flops so it rises with the pin value
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        step_q <= 1'b0;
        tick_q <= 1'b0;
        outbound_strobe[k] <= 1'b0;
      end
      else
      begin
        step_q <= step;
        tick_q <= tick;
        if (step_q)
          outbound_strobe[k] <= dir_out && ctrl[k][`TIO_CTRL_SOUT];  // R15
        else if (tick_q)
          outbound_strobe[k] <= 1'b0;
      end
    end

    assign done[k] = step && step_cnt == LAST;
    assign lane_out[k] = lane_drv;

    // Readback of this port
    always_comb
    begin
      case (addr[2:0])
        `TIO_REG_CTRL: port_rd[k] = ctrl[k]
          | (32'(state == tio_pkg::PS_HOLD) << `TIO_CTRL_VALID)
          | (32'(state == tio_pkg::PS_BUSY && dir_out) << `TIO_CTRL_BUSY);
        `TIO_REG_COND: port_rd[k] = cond_val;
        `TIO_REG_TIME: port_rd[k] = {16'h0000, time_val};
        `TIO_REG_DATA: port_rd[k] = xfer;
        `TIO_REG_COUNT: port_rd[k] = {16'h0000, count};  // R8
        `TIO_REG_STAMP: port_rd[k] = {16'h0000, stamp};  // R9
        default: port_rd[k] = 32'h0000_0000;
      endcase
    end
  end

  // Pin drivers from the owning output port
  for (genvar i = 0; i < 32; i++)
  begin : pin_g
    logic drv;
    logic od;
    logic val;
    always_comb
    begin
      drv = 1'b0;
      od = 1'b0;
      val = 1'b0;
      for (int k = 0; k < NP; k++)
        if (own[i][k] && ctrl[k][`TIO_CTRL_DIR_OUT])
        begin
          drv = 1'b1;  // R11
          od = ctrl[k][`TIO_CTRL_OD];
          val = lane_out[k][i];
        end
    end
    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        pin_out[i] <= 1'b0;
        pin_oe_n[i] <= 1'b1;
      end
      else
      begin
        pin_out[i] <= od ? 1'b0 : val;
        pin_oe_n[i] <= !drv || (od && val);  // R5
      end
    end
  end

  // Event pulses go straight to the tile
  always_ff @(posedge clk)
  begin
    if (rst)
      port_event <= 5'h00;
    else
      port_event <= done;  // R17
  end

  // Sticky status, set wins over write-one-to-clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_stat <= 5'h00;
      irq_mask <= 5'h00;
    end
    else
    begin
      if (wr && addr == `TIO_REG_IRQ_STAT)
        irq_stat <= (irq_stat & ~wdata[4:0]) | done;
      else
        irq_stat <= irq_stat | done;
      if (wr && addr == `TIO_REG_IRQ_MASK)
        irq_mask <= wdata[4:0];
    end
  end

  // Interrupt level from unmasked status
  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // Read data one cycle after the strobe, never a wait
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      if (addr[5:3] < 3'(NP))
        rdata <= port_rd[addr[5:3]];  // R4
      else if (addr == `TIO_REG_LINK)
        rdata <= {31'h0, link_en};
      else if (addr == `TIO_REG_IRQ_STAT)
        rdata <= {27'h0, irq_stat};
      else if (addr == `TIO_REG_IRQ_MASK)
        rdata <= {27'h0, irq_mask};
      else if (addr[5:3] == `TIO_CB_PAGE && addr[2:0] != 3'h0 && addr[2:0] < 3'(`TIO_NCB))
        rdata <= {16'h0000, cb_cfg[addr[2:0]]};
      else
        rdata <= 32'h0000_0000;
    end
    else
      rdata <= 32'h0000_0000;
  end

endmodule : tio_port_block

/* File: tb/tio_port_block_properties.sv */
`timescale 1ns/1ns
module tio_port_block_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [5:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Pins
  input wire logic [31:0] pin_in,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  // Strobes, events, interrupt
  input wire logic [4:0] inbound_strobe,
  input wire logic [4:0] outbound_strobe,
  input wire logic [4:0] port_event,
  input wire logic irq
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // A word of the narrow ports needs many steps
  sequence quiet0;
    !port_event[0] [*8];
  endsequence
  sequence quiet1;
    !port_event[1] [*7];
  endsequence
  // Bus, pin and event relations
  chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_od_release: assert property ((pin_out & pin_oe_n) == 32'h0)
    else $error("released pin carries a high value");
  chk_event_pulse: assert property (port_event != 5'h0 |=> (port_event & $past(port_event)) == 5'h0)
    else $error("event longer than one cycle");
  chk_word_gap0: assert property (port_event[0] |=> quiet0)
    else $error("one-bit word too short");
  chk_word_gap1: assert property (port_event[1] |=> quiet1)
    else $error("four-bit word too short");
  chk_reset_outputs: assert property ($fell(rst) |-> pin_oe_n == 32'hffff_ffff && pin_out == 32'h0
    && irq == 1'b0 && port_event == 5'h0 && outbound_strobe == 5'h0)
    else $error("outputs not at rest after reset");
  chk_irq_rise: assert property ($rose(irq) |-> $past(|port_event || wr)
    || $past(|port_event || wr, 2) || $past(|port_event || wr, 3))
    else $error("interrupt rose without cause");
  chk_irq_fall: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("interrupt fell without a write");
endmodule : tio_port_block_properties

bind tio_port_block tio_port_block_properties chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pin_in,
  .pin_out, .pin_oe_n, .inbound_strobe, .outbound_strobe, .port_event, .irq);

/* File: tb/tio_pin_model.sv */
`timescale 1ns/1ns
module tio_pin_model (
  // Pins of the design
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe_n,
  output logic [31:0] pin_in,
  // Far side values from the bench
  input wire logic [31:0] ext_val,
  input wire logic [4:0] ext_strobe,
  output logic [4:0] inbound_strobe
);
  // Link clock on pin 0, still between bursts
  logic lclk = 1'b0;
  // Released pins show the far side; idle pins pull down
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & (ext_val | {31'h0, lclk}));
  // Strobe qualifies data that the bench holds steady
  assign inbound_strobe = ext_strobe;
  // Burst of link clock edges, 125 ns period
  task automatic run_lclk(input int n);
    #3;
    repeat (n)
    begin
      lclk = 1'b1;
      #62;
      lclk = 1'b0;
      #63;
    end
  endtask : run_lclk
endmodule : tio_pin_model

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  // Design inputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] ext_strobe = 5'h00;
  logic [31:0] ext_val = 32'h0;
  // Design outputs
  logic [31:0] rdata, pin_in, pin_out, pin_oe_n;
  logic [4:0] inbound_strobe, outbound_strobe, port_event;
  logic irq;
  // Bench state
  integer seed = 32'h12eb;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int w, n;
  logic [31:0] c0, v, m, ch, eo, ee;
  logic [4:0] ev = 5'h00;

  always #5 clk = ~clk;

  // Event pulses seen half a cycle later, so a look at the next pin edge still finds them
  always @(negedge clk) ev <= port_event;

  tio_port_block uut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe_n,
    .inbound_strobe, .outbound_strobe, .port_event, .irq);
  tio_pin_model pm (.pin_out, .pin_oe_n, .pin_in, .ext_val, .ext_strobe, .inbound_strobe);

  // Chunk i of a word for a port w bits wide
  function automatic logic [31:0] chunk(input int w, input logic [31:0] d, input int i);
    return 32'((64'(d) >> (i * w)) & ((64'h1 << w) - 64'h1));
  endfunction : chunk

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      failures = failures + 1;
      $display("[FAIL] %0t: got %h, expected %h", $time, g, e);
    end
  endtask : check

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg

  task automatic rreg(input logic [5:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rreg

  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] g;
    rreg(a, g);
    check(g, e);
  endtask : rchk

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // Cuts a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      failures = failures + 1;
      $display("[FAIL] %0t: run took too long", $time);
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int k = 0; k < 5; k++)
      rchk(6'(k * 8), 32'h0);
    rchk(6'h3f, 32'h0);
    check(pin_oe_n, 32'hffff_ffff);
    $display("reset test done");
    // Counter follows the reference clock
    wreg(6'h08, 32'h3);
    v = $random(seed) & 32'h7;
    rreg(6'h0c, c0);
    cyc(v);
    rchk(6'h0c, {16'h0, 16'(c0[15:0] + v[15:0] + 16'h2)});
    wreg(6'h08, 32'h0);
    $display("counter test done");
    // One output word per port, LSB chunk first
    for (int k = 0; k < 5; k++)
    begin
      w = (k == 0) ? 1 : 4 << (k - 1);
      n = 32 / w;
      m = chunk(w, 32'hffff_ffff, 0);
      v = $random(seed);
      wreg(6'h2a, (k == 2) ? 32'h0 : 32'h1f);
      wreg(6'h28, {31'h0, k == 4});
      wreg(6'(k * 8), (k == 1) ? 32'h7 : (k == 2) ? 32'h203 : 32'h3);
      rreg(6'(k * 8 + 4), c0);
      wreg(6'(k * 8 + 3), v);
      for (int i = 0; i < n; i++)
      begin
        @(posedge clk);
        #1 ch = chunk(w, v, i);
        eo = (k == 1) ? 32'h0 : ch;
        ee = (k == 1) ? ch : 32'h0;
        if (k == 4)
        begin
          eo = eo & 32'hfff0_ffff;
          ee = ee | 32'h000f_0000;
        end
        check(pin_out & m, eo);
        check(pin_oe_n & m, ee);
        check({27'h0, outbound_strobe}, (k == 2) ? 32'h4 : 32'h0);
        if (i == n - 1)
          check({27'h0, ev}, 32'h1 << k);
      end
      @(posedge clk);
      cyc(2);
      check({31'h0, irq}, {31'h0, k != 2});
      check({27'h0, outbound_strobe}, 32'h0);
      rchk(6'(k * 8 + 5), {16'h0, 16'(c0[15:0] + 16'(n) + 16'h2)});
      rchk(6'h29, 32'h1 << k);
      wreg(6'h29, 32'h1 << k);
      cyc(2);
      check({31'h0, irq}, 32'h0);
      wreg(6'(k * 8), 32'h0);
    end
    wreg(6'h28, 32'h0);
    $display("output test done");
    // Transfer held until a programmed count
    wreg(6'h20, 32'h3);
    rreg(6'h24, c0);
    wreg(6'h22, {16'h0, 16'(c0[15:0] + 16'h1e)});
    wreg(6'h23, v);
    cyc(40);
    rchk(6'h25, {16'h0, 16'(c0[15:0] + 16'h1e)});
    wreg(6'h29, 32'h10);
    wreg(6'h20, 32'h0);
    $display("timed test done");
    // Counter paced by divided pin clock
    v = $random(seed) & 32'h3;
    wreg(6'h31, (v << 8) | 32'h1);
    wreg(6'h08, 32'h9);
    rreg(6'h0c, c0);
    pm.run_lclk((v + 1) * 4);
    @(posedge clk);
    cyc(4);
    rchk(6'h0c, {16'h0, 16'(c0[15:0] + 16'h4)});
    wreg(6'h08, 32'h0);
    $display("clock block test done");
    // Input waits for strobe and pin condition
    v = $random(seed);
    wreg(6'h21, v);
    wreg(6'h20, 32'h141);
    ext_val <= v;
    cyc(8);
    rchk(6'h20, 32'h141);
    ext_strobe <= 5'h10;
    ext_val <= ~v;
    cyc(8);
    rchk(6'h20, 32'h141);
    ext_val <= v;
    cyc(8);
    ext_strobe <= 5'h00;
    rchk(6'h20, 32'h0001_0141);
    rchk(6'h23, v);
    // Not-equal condition holds off while the pins still match
    wreg(6'h20, 32'h81);
    cyc(8);
    rchk(6'h20, 32'h81);
    ext_val <= ~v;
    cyc(8);
    rchk(6'h20, 32'h0001_0081);
    rchk(6'h23, ~v);
    wreg(6'h20, 32'h0);
    wreg(6'h29, 32'h10);
    $display("input test done");
    finish_test();
  end
endmodule : tb
